// [core/becc_top.sv]
// Contract
// RULE_01: On error, data lines 31..0 of the command cycle go to low register.
// RULE_02: Data lines 34..32 go to high register bits 2..0.
// RULE_03: Command lines, data 37..35, go to high register bits 5..3.
// RULE_04: Commands: 000 read,001 write,011 victim,100/101 CSR rd/wr,111 private.
// RULE_05: Parity bit, data line 38, goes to high register bit 6.
// RULE_06: Four request lines go to high register bits 10..7 as commander.
// RULE_07: High bit 15 records confirmation asserted for the captured command.
// RULE_08: High bit 17 records dirty asserted; may be omitted on I/O ports.
// RULE_09: High bit 16 records shared asserted; may be omitted on I/O ports.
// RULE_10: High bits 19..18 give which data beat 0..3 held the error.
// RULE_11: Lock on bus error bits 1, 3, 5, 7 and 12.
// RULE_12: Lock on interface error bits 10 and 6..0.
// RULE_13: Locked registers ignore cycles until flags clear; reserved bits read zero.
`timescale 1ns/1ps
module becc_top #(
  parameter bit HAS_COHERENCE = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [38:0] bus_data,
  input wire logic [3:0] bus_req,
  input wire logic bus_confirm_line,
  input wire logic bus_shared_line,
  input wire logic bus_dirty_line,
  input wire logic bus_cmd_cycle,
  input wire logic [1:0] error_data_beat,
  input wire logic [15:0] bus_error_summary,
  input wire logic [15:0] interface_error_summary,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic locked,
  output logic irq
);

  // ==========================================================================
  // Pin synchronisation.
  localparam int PW = 39 + 4 + 3 + 1 + 2;
  logic [PW-1:0] pins_raw, pins_s;
  becc_pkg::becc_cycle_t cyc;
  logic cmd_s;
  logic [1:0] beat_s;

  // All bus pins except the two error summaries cross two flops; the bench must hold them stable one cycle.
  assign pins_raw = {bus_data, bus_req, bus_confirm_line, bus_shared_line,
                     bus_dirty_line, bus_cmd_cycle, error_data_beat};

  becc_sync #(.WIDTH(PW)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pins_raw),
    .q(pins_s)
  );

  assign cyc = becc_pkg::becc_cycle_t'(pins_s[PW-1:3]);
  assign cmd_s = pins_s[2];
  assign beat_s = pins_s[1:0];

  // ==========================================================================
  // Register bus.
  logic wr_en, rd_en, rd_hit, wr_hit;
  logic [11:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;

  becc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit),
    .wr_hit(wr_hit)
  );

  // ==========================================================================
  // Lock condition.
  function automatic logic lock_cause(input logic [15:0] be, input logic [15:0] ie);
    lock_cause = |(be & becc_pkg::BE_LOCK_MASK) | |(ie & becc_pkg::IE_LOCK_MASK);
  endfunction

  // Any listed error in a command cycle triggers the capture.
  logic err_now;
  assign err_now = cmd_s &&
    lock_cause(bus_error_summary, interface_error_summary); // RULE_11 RULE_12

  // ==========================================================================
  // Capture state.
  becc_pkg::becc_state_t st_r, st_nxt;
  logic [31:0] low_r, low_nxt, high_r, high_nxt;
  logic clear_req, take;

  // Software releases the lock by writing one to bit 0 of the clear register,
  // which stands in for clearing the summary flags of the error registers.
  assign clear_req = wr_en && (wr_addr == becc_pkg::ADDR_CLEAR) && wr_data[0];

  always_comb begin
    st_nxt = st_r;
    low_nxt = low_r;
    high_nxt = high_r;
    take = 1'b0;
    case (st_r)
      becc_pkg::ST_OPEN: begin
        take = err_now;
      end
      becc_pkg::ST_LOCKED: begin
        // Further cycles are ignored; the clear reopens capture. An error in the
        // very cycle of the clear is taken at once, so the set wins over the clear.
        take = err_now && clear_req;
        if (clear_req) begin
          st_nxt = becc_pkg::ST_OPEN; // RULE_13
        end
      end
      default: st_nxt = becc_pkg::ST_OPEN;
    endcase
    if (take) begin
      st_nxt = becc_pkg::ST_LOCKED;
      low_nxt = cyc.data[31:0]; // RULE_01
      high_nxt = becc_pkg::RST_ZERO; // RULE_13
      high_nxt[becc_pkg::HI_ADDR_LSB +: 3] = cyc.data[34:32]; // RULE_02
      high_nxt[becc_pkg::HI_CMD_LSB +: 3] = cyc.data[37:35]; // RULE_03 RULE_04
      high_nxt[becc_pkg::HI_PAR_BIT] = cyc.data[38]; // RULE_05
      high_nxt[becc_pkg::HI_NODE_LSB +: 4] = cyc.req; // RULE_06
      high_nxt[becc_pkg::HI_CONF_BIT] = cyc.confirm_line; // RULE_07
      high_nxt[becc_pkg::HI_DIRTY_BIT] = HAS_COHERENCE & cyc.dirty_line; // RULE_08
      high_nxt[becc_pkg::HI_SHARED_BIT] = HAS_COHERENCE & cyc.shared_line; // RULE_09
      high_nxt[becc_pkg::HI_BEAT_LSB +: 2] = beat_s; // RULE_10
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= becc_pkg::ST_OPEN;
      low_r <= becc_pkg::RST_ZERO;
      high_r <= becc_pkg::RST_ZERO;
    end else begin
      st_r <= st_nxt;
      low_r <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign locked = (st_r == becc_pkg::ST_LOCKED);

  // ==========================================================================
  // Interrupt status and mask.
  logic [1:0] sts_r, sts_nxt, msk_r, msk_nxt, evt;

  // Event 0 is a new lock, event 1 an error lost while already locked.
  assign evt[becc_pkg::EVT_LOCK] = take;
  assign evt[becc_pkg::EVT_MISS] = err_now && !take;

  // A set in the same cycle as a write-one-clear wins, so no event is lost.
  always_comb begin
    sts_nxt = sts_r;
    msk_nxt = msk_r;
    if (wr_en && wr_addr == becc_pkg::ADDR_STATUS) begin
      sts_nxt = sts_r & ~wr_data[1:0];
    end
    if (wr_en && wr_addr == becc_pkg::ADDR_MASK) begin
      msk_nxt = wr_data[1:0];
    end
    sts_nxt = sts_nxt | evt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r <= 2'h0;
      msk_r <= becc_pkg::RST_EVT_MASK;
    end else begin
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
    end
  end

  assign irq = |(sts_r & msk_r);

  // ==========================================================================
  // Read decode; capture registers are read-only, writes to them error.
  always_comb begin
    rd_data = becc_pkg::RST_ZERO;
    rd_hit = 1'b1;
    case (rd_addr)
      becc_pkg::ADDR_LOW: rd_data = low_r;
      becc_pkg::ADDR_HIGH: rd_data = high_r; // RULE_13
      becc_pkg::ADDR_STATUS: rd_data = {30'h0000_0000, sts_r};
      becc_pkg::ADDR_MASK: rd_data = {30'h0000_0000, msk_r};
      becc_pkg::ADDR_CLEAR: rd_data = {31'h0000_0000, locked};
      default: rd_hit = 1'b0;
    endcase
  end

  assign wr_hit = (wr_addr == becc_pkg::ADDR_STATUS) ||
                  (wr_addr == becc_pkg::ADDR_MASK) ||
                  (wr_addr == becc_pkg::ADDR_CLEAR);

  // ==========================================================================
  // Checks.
  property p_capture_low;
    @(posedge aclk) disable iff (!aresetn)
      (err_now && !locked) |=> (low_r == $past(cyc.data[31:0]));
  endproperty
  a_capture_low: assert property (p_capture_low) // RULE_01
    else $error("low capture mismatch");

  property p_capture_addr_hi;
    @(posedge aclk) disable iff (!aresetn)
      (err_now && !locked) |=> (high_r[2:0] == $past(cyc.data[34:32]));
  endproperty
  a_capture_addr_hi: assert property (p_capture_addr_hi) // RULE_02
    else $error("high address capture mismatch");

  property p_capture_cmd;
    @(posedge aclk) disable iff (!aresetn)
      (err_now && !locked) |=> (high_r[6:3] == $past(cyc.data[38:35]));
  endproperty
  a_capture_cmd: assert property (p_capture_cmd) // RULE_03
    else $error("command or parity capture mismatch");

  property p_capture_node;
    @(posedge aclk) disable iff (!aresetn)
      (err_now && !locked) |=> (high_r[10:7] == $past(cyc.req)) &&
      (high_r[15] == $past(cyc.confirm_line));
  endproperty
  a_capture_node: assert property (p_capture_node) // RULE_06
    else $error("commander or confirm capture mismatch");

  property p_capture_beat;
    @(posedge aclk) disable iff (!aresetn)
      (err_now && !locked) |=> (high_r[19:18] == $past(beat_s));
  endproperty
  a_capture_beat: assert property (p_capture_beat) // RULE_10
    else $error("data beat capture mismatch");

  property p_lock_on_error;
    @(posedge aclk) disable iff (!aresetn)
      err_now |=> locked;
  endproperty
  a_lock_on_error: assert property (p_lock_on_error) // RULE_11
    else $error("error did not lock capture");

  property p_hold_while_locked;
    @(posedge aclk) disable iff (!aresetn)
      (locked && !clear_req) |=> locked && $stable(low_r) && $stable(high_r);
  endproperty
  a_hold_while_locked: assert property (p_hold_while_locked) // RULE_13
    else $error("locked capture changed");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      (high_r[31:20] == 12'h000) && (high_r[14:11] == 4'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE_13
    else $error("reserved bits not zero");

  property p_no_lock_without_cause;
    @(posedge aclk) disable iff (!aresetn)
      (!locked && !err_now) |=> !locked;
  endproperty
  a_no_lock_without_cause: assert property (p_no_lock_without_cause) // RULE_12
    else $error("capture locked without cause");

endmodule

// [pkg/becc_pkg.sv]
package becc_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [11:0] ADDR_LOW = 12'h0700;
  localparam logic [11:0] ADDR_HIGH = 12'h0740;
  localparam logic [11:0] ADDR_STATUS = 12'h0780;
  localparam logic [11:0] ADDR_MASK = 12'h0784;
  localparam logic [11:0] ADDR_CLEAR = 12'h0788;

  // ==========================================================================
  // Field positions of the high capture register.
  localparam int HI_ADDR_LSB = 0;
  localparam int HI_CMD_LSB = 3;
  localparam int HI_PAR_BIT = 6;
  localparam int HI_NODE_LSB = 7;
  localparam int HI_CONF_BIT = 15;
  localparam int HI_SHARED_BIT = 16;
  localparam int HI_DIRTY_BIT = 17;
  localparam int HI_BEAT_LSB = 18;

  // Bus error summary bits that lock capture.
  localparam int BE_UNCORR = 1;
  localparam int BE_CORR = 3;
  localparam int BE_CMDPAR = 5;
  localparam int BE_CSRPAR = 7;
  localparam int BE_NXADDR = 12;
  localparam logic [15:0] BE_LOCK_MASK = 16'h10AA;
  // Interface error summary bits that lock capture.
  localparam logic [15:0] IE_LOCK_MASK = 16'h047F;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RST_EVT_MASK = 2'h0;

  // Interrupt status bits.
  localparam int EVT_LOCK = 0;
  localparam int EVT_MISS = 1;

  // Command codes.
  typedef enum logic [2:0] {
    CMD_READ = 3'b000,
    CMD_WRITE = 3'b001,
    CMD_RSVD2 = 3'b010,
    CMD_VICTIM = 3'b011,
    CMD_CSR_RD = 3'b100,
    CMD_CSR_WR = 3'b101,
    CMD_RSVD6 = 3'b110,
    CMD_PRIV = 3'b111
  } becc_cmd_t;

  // One sampled bus command cycle.
  typedef struct packed {
    logic [38:0] data;
    logic [3:0] req;
    logic confirm_line;
    logic shared_line;
    logic dirty_line;
  } becc_cycle_t;

  // Capture state.
  typedef enum logic [0:0] {
    ST_OPEN = 1'b0,
    ST_LOCKED = 1'b1
  } becc_state_t;

endpackage

// [core/becc_sync.sv]
`timescale 1ns/1ps
module becc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // Two stage synchroniser; only the second stage is visible.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// [core/becc_axil.sv]
`timescale 1ns/1ps
module becc_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic rd_en,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit,
  input wire logic wr_hit
);

  logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [11:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;

  // Address and data are held separately so either may arrive first.
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    b_nxt = b_r;
    br_nxt = br_r;
    r_nxt = r_r;
    rr_nxt = rr_r;
    rd_nxt = rd_r;
    if (s_awvalid && s_awready) begin
      aw_nxt = 1'b1;
      awa_nxt = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_nxt = 1'b1;
      wd_nxt = s_wdata;
    end
    if (wr_en) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      b_nxt = 1'b1;
      br_nxt = wr_hit ? 2'b00 : 2'b10;
    end else if (s_bvalid && s_bready) begin
      b_nxt = 1'b0;
    end
    if (rd_en) begin
      r_nxt = 1'b1;
      rd_nxt = rd_data;
      rr_nxt = rd_hit ? 2'b00 : 2'b10;
    end else if (s_rvalid && s_rready) begin
      r_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      b_r <= 1'b0;
      r_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      rd_r <= '0;
      br_r <= '0;
      rr_r <= '0;
    end else begin
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      b_r <= b_nxt;
      r_r <= r_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      br_r <= br_nxt;
      rr_r <= rr_nxt;
    end
  end

  // Byte strobes are ignored: every writable bit is a whole-word action.
  assign s_awready = !aw_r && !b_r;
  assign s_wready = !w_r && !b_r;
  assign wr_en = aw_r && w_r && !b_r;
  assign wr_addr = awa_r;
  assign wr_data = wd_r;
  assign s_bvalid = b_r;
  assign s_bresp = br_r;
  assign s_arready = !r_r;
  assign rd_en = s_arvalid && !r_r;
  assign rd_addr = s_araddr;
  assign s_rvalid = r_r;
  assign s_rdata = rd_r;
  assign s_rresp = rr_r;

endmodule

// [tb/becc_bus_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Far side of the capture block: a commander driving one command cycle.
module becc_bus_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire becc_pkg::becc_cycle_t cyc,
  input wire logic [1:0] beat,
  input wire logic [15:0] be_in,
  input wire logic [15:0] ie_in,
  output logic [38:0] bus_data,
  output logic [3:0] bus_req,
  output logic bus_confirm_line,
  output logic bus_shared_line,
  output logic bus_dirty_line,
  output logic bus_cmd_cycle,
  output logic [1:0] error_data_beat,
  output logic [15:0] bus_error_summary,
  output logic [15:0] interface_error_summary
);
  logic [2:0] cnt_r = 3'h0;
  becc_pkg::becc_cycle_t cyc_r = '0;
  logic [1:0] beat_r = 2'h0;
  logic [15:0] be_r = 16'h0000;
  logic [15:0] ie_r = 16'h0000;
  logic live;

  // A request is latched whole; the cycle then stands for five edges.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 3'h0;
    end else if (start) begin
      cnt_r <= 3'h1;
      cyc_r <= cyc;
      beat_r <= beat;
      be_r <= be_in;
      ie_r <= ie_in;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= (cnt_r == 3'h5) ? 3'h0 : cnt_r + 3'h1;
    end
  end

  // Outside a cycle the lines show the inverse of the last value, so a
  // capture taken at the wrong moment cannot match by luck.
  always_comb begin
    live = (cnt_r != 3'h0);
    bus_cmd_cycle = live;
    bus_data = live ? cyc_r.data : ~cyc_r.data;
    bus_req = live ? cyc_r.req : ~cyc_r.req;
    bus_confirm_line = live ? cyc_r.confirm_line : ~cyc_r.confirm_line;
    bus_shared_line = live ? cyc_r.shared_line : ~cyc_r.shared_line;
    bus_dirty_line = live ? cyc_r.dirty_line : ~cyc_r.dirty_line;
    error_data_beat = live ? beat_r : ~beat_r;
    // Flags come two edges after the pins so they meet the resynced copy.
    bus_error_summary = (cnt_r == 3'h3) ? be_r : 16'h0000;
    interface_error_summary = (cnt_r == 3'h3) ? ie_r : 16'h0000;
  end
endmodule

// [tb/becc_tb_top.sv]
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the error command capture block.
module bus_error_command_capture_tb_top;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] SE = 2'h2;
  logic aclk = 1'b0;
  logic aresetn, start, locked, irq;
  becc_pkg::becc_cycle_t cyc;
  logic [1:0] beat;
  logic [15:0] be_in, ie_in, be_sum, ie_sum;
  logic [38:0] bus_data;
  logic [3:0] bus_req, s_wstrb;
  logic conf, shrd, drty, cmd_cyc;
  logic [1:0] ebeat, s_bresp, s_rresp;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int err_count = 0;
  int num_checks = 0;
  int lb [13] = '{1, 3, 5, 7, 12, 0, 1, 2, 3, 4, 5, 6, 10};

  // ========================================================================
  // Clock and instances.
  initial begin
    forever #4 aclk = ~aclk;
  end

  becc_bus_model u_becc_bus_model (.aclk(aclk), .aresetn(aresetn), .start(start), .cyc(cyc),
    .beat(beat), .be_in(be_in), .ie_in(ie_in), .bus_data(bus_data), .bus_req(bus_req),
    .bus_confirm_line(conf), .bus_shared_line(shrd), .bus_dirty_line(drty),
    .bus_cmd_cycle(cmd_cyc), .error_data_beat(ebeat), .bus_error_summary(be_sum),
    .interface_error_summary(ie_sum));

  becc_top u_becc_top (.aclk(aclk), .aresetn(aresetn), .bus_data(bus_data), .bus_req(bus_req),
    .bus_confirm_line(conf), .bus_shared_line(shrd), .bus_dirty_line(drty),
    .bus_cmd_cycle(cmd_cyc), .error_data_beat(ebeat), .bus_error_summary(be_sum),
    .interface_error_summary(ie_sum), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .locked(locked), .irq(irq));

  // ========================================================================
  // Checking helpers.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Reserved bits are built in as zeros, so a stray one shows as a mismatch.
  function automatic logic [31:0] exp_hi(input becc_pkg::becc_cycle_t c, input logic [1:0] b);
    return {12'h000, b, c.dirty_line, c.shared_line, c.confirm_line, 4'h0, c.req,
      c.data[38:32]};
  endfunction

  task automatic final_report();
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // Register bus master; every wait ends only on the slave's answer.
  // Both response readies stay high, so back-to-back calls never toggle them.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_d, w_d, b_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    b_d = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!b_d) begin
      @(posedge aclk);
      if (!aw_d && s_awready) begin
        aw_d = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_d && s_wready) begin
        w_d = 1'b1;
        s_wvalid <= 1'b0;
      end
      if (s_bvalid) begin
        b_d = 1'b1;
        chk("bresp", 32'(er), 32'(s_bresp));
      end
    end
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
      input string nm);
    logic ar_d, r_d;
    ar_d = 1'b0;
    r_d = 1'b0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    while (!r_d) begin
      @(posedge aclk);
      if (!ar_d && s_arready) begin
        ar_d = 1'b1;
        s_arvalid <= 1'b0;
      end
      if (s_rvalid) begin
        r_d = 1'b1;
        chk("rresp", 32'(er), 32'(s_rresp));
        chk(nm, e, s_rdata);
      end
    end
  endtask

  // Launches one command cycle on the far side and allows it time to land.
  task automatic fire(input becc_pkg::becc_cycle_t c, input logic [1:0] b,
      input logic [15:0] be, input logic [15:0] ie);
    cyc <= c;
    beat <= b;
    be_in <= be;
    ie_in <= ie;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  // ========================================================================
  // Main sequence.
  initial begin
    becc_pkg::becc_cycle_t c, c2;
    logic [1:0] b;
    logic [15:0] be, ie;
    aresetn = 1'b0;
    start = 1'b0;
    cyc = '0;
    beat = 2'h0;
    be_in = 16'h0000;
    ie_in = 16'h0000;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    {s_awvalid, s_wvalid, s_arvalid} = '0;
    s_bready = 1'b1;
    s_rready = 1'b1;
    void'($urandom(97012));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Cleared state, refused writes and an unmapped hole.
    axr(becc_pkg::ADDR_LOW, 32'h0000_0000, OK, "low_rst");
    axr(becc_pkg::ADDR_HIGH, 32'h0000_0000, OK, "high_rst");
    axr(becc_pkg::ADDR_STATUS, 32'h0000_0000, OK, "status_rst");
    axr(becc_pkg::ADDR_MASK, 32'h0000_0000, OK, "mask_rst");
    axr(12'h004, 32'h0000_0000, SE, "unmapped_rd");
    axw(becc_pkg::ADDR_LOW, 32'hFFFF_FFFF, SE);
    axw(becc_pkg::ADDR_HIGH, 32'hFFFF_FFFF, SE);
    axw(12'hFFC, 32'h0000_0001, SE);
    // Every flag that must not lock, all at once.
    fire(46'({$urandom, $urandom}), 2'h1, ~becc_pkg::BE_LOCK_MASK, ~becc_pkg::IE_LOCK_MASK);
    chk("locked_nolock", 32'h0000_0000, 32'(locked));
    // Each locking flag in turn, every command code, mask on and off.
    for (int i = 0; i < 13; i++) begin
      c = 46'({$urandom, $urandom});
      c.data[37:35] = 3'(i % 8);
      b = 2'($urandom);
      be = (i < 5) ? (16'h0001 << lb[i]) : 16'h0000;
      ie = (i < 5) ? 16'h0000 : (16'h0001 << lb[i]);
      axw(becc_pkg::ADDR_MASK, 32'(i % 2), OK);
      fire(c, b, be, ie);
      chk("locked", 32'h0000_0001, 32'(locked));
      chk("locked_if", 32'h0000_0001, 32'(locked));
      axr(becc_pkg::ADDR_LOW, c.data[31:0], OK, "low");
      axr(becc_pkg::ADDR_HIGH, exp_hi(c, b), OK, "high");
      axr(becc_pkg::ADDR_HIGH, exp_hi(c, b), OK, "high_cmd");
      @(posedge aclk);
      chk("irq", 32'(i % 2), 32'(irq));
      // A second error while locked must leave the capture alone.
      c2 = ~c;
      fire(c2, ~b, be, ie);
      axr(becc_pkg::ADDR_LOW, c.data[31:0], OK, "low_held");
      axr(becc_pkg::ADDR_HIGH, exp_hi(c, b), OK, "high_held");
      axr(becc_pkg::ADDR_STATUS, 32'h0000_0003, OK, "status");
      axr(becc_pkg::ADDR_CLEAR, 32'h0000_0001, OK, "lock_rd");
      axw(becc_pkg::ADDR_STATUS, 32'h0000_0003, OK);
      axr(becc_pkg::ADDR_STATUS, 32'h0000_0000, OK, "status_clr");
      @(posedge aclk);
      chk("irq_clr", 32'h0000_0000, 32'(irq));
      axw(becc_pkg::ADDR_CLEAR, 32'h0000_0001, OK);
      axr(becc_pkg::ADDR_CLEAR, 32'h0000_0000, OK, "unlock_rd");
    end
    final_report();
  end

  // Whole run is under a thousand cycles; this cuts off a hung handshake.
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    final_report();
  end
endmodule
